// ==== inc/spi_frame_pkg.sv ====
// Purpose: Shared constants and types of the serial command port.
// Assumes: 40-bit frames, address byte first, MSB first.
// Notes:   Bits 7..4 of the status byte always read zero.
package spi_frame_pkg;
  // ---------------------------------------------
  // Frame layout
  // ---------------------------------------------
  localparam int         FRAME_BITS  = 40;
  localparam int         DATA_BITS   = 32;
  localparam int         ADDR_BITS   = 7;
  localparam int         STAT_BITS   = 8;
  localparam int         DIR_BIT     = 39;
  localparam int         ADDR_MSB    = 38;
  localparam int         ADDR_LSB    = 32;
  localparam int         CNT_BITS    = 6;
  localparam logic [5:0] FRAME_COUNT = 6'h28;
  // ---------------------------------------------
  // Status byte sources
  // ---------------------------------------------
  localparam int         DRV_STANDSTILL_BIT = 31;
  localparam int         DRV_STALL_BIT      = 24;
  localparam int         GLOBAL_STATUS_REG_ERR_BIT      = 1;
  localparam int         GLOBAL_STATUS_REG_RESET_BIT    = 0;
  localparam logic [6:0] GLOBAL_STATUS_ADDR = 7'h01;
  // ---------------------------------------------
  // Reset values and timing
  // ---------------------------------------------
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [31:0] DATA_RESET   = 32'h00000000;
  localparam int          SYNC_STAGES  = 2;
  // Frame-end sequencer of the system side
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LATCH = 2'b01,
    ST_ACT   = 2'b10
  } frame_state_t;
endpackage

// ==== inc/frame_link_if.sv ====
// Purpose: Carries the frame words between system side and link side.
// Assumes: Words only change while the other side is known to be idle.
// Notes:   Crossing is qualified by the synchronised chip select.
`timescale 1ns/100ps
`default_nettype none
interface frame_link_if;
  // Response loaded at the first rising bus clock edge of a frame
  logic [spi_frame_pkg::FRAME_BITS-1:0] resp_word;
  // Last 40 bits shifted in, stable while chip select is high
  logic [spi_frame_pkg::FRAME_BITS-1:0] frame_word;
  // At least 40 bus clocks were seen in the last frame
  logic                                 frame_full;
  modport link (input resp_word, output frame_word, output frame_full);
  modport core (output resp_word, input frame_word, input frame_full);
endinterface
`default_nettype wire

// ==== verilog/level_sync.sv ====
// Purpose: Two-stage synchroniser for levels entering sys_clk.
// Assumes: Inputs are levels that hold for several clocks.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
  parameter int               WIDTH      = 1,
  parameter logic [WIDTH-1:0] RESET_BITS = '0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // ---------------------------------------------
  // One flop pair per bit
  // ---------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic meta;  // Metastable stage, read only below
      logic held;  // Settled stage
      // Reset picks the idle level so no false edge appears
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          meta <= RESET_BITS[i];
          held <= RESET_BITS[i];
        end else begin
          meta <= async_in[i];
          held <= meta;
        end
      end
      assign sync_out[i] = held;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verilog/frame_shifter.sv ====
// Purpose: Bus-clock side of the port: 40-bit shift path and output.
// Assumes: Bus clock idles high and only toggles while selected.
// Notes:   Chip select high resets the output bit and arms a new frame.
`timescale 1ns/100ps
`default_nettype none
module frame_shifter (
  // Link clock and pins
  input  wire logic   bus_clock,
  input  wire logic   chip_select_low,
  input  wire logic   serial_in,
  output logic        serial_out,
  // Words shared with the system side
  frame_link_if.link  link
);
  logic        fresh;      // No edge yet in this frame
  logic [5:0]  bit_count;  // Saturating bus clock count
  logic [39:0] shift_reg;  // Shared in/out shift path
  logic        out_bit;    // Falling-edge output flop

  // ---------------------------------------------
  // Next values
  // ---------------------------------------------
  // First edge loads the response above the incoming bit
  wire [39:0] next_shift = fresh ? {link.resp_word[38:0], serial_in}
                                 : {shift_reg[38:0], serial_in};  // RL5 RL16
  // Count stops at 40, enough to qualify the frame
  wire        at_full    = (bit_count == spi_frame_pkg::FRAME_COUNT);
  wire [5:0]  next_count = fresh ? 6'h01 : (at_full ? bit_count : bit_count + 6'h01);

  // Chip select high re-arms; preset is a constant
  always_ff @(posedge bus_clock or posedge chip_select_low) begin
    if (chip_select_low) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Input sampled on the rising edge, MSB first
  always_ff @(posedge bus_clock) begin
    shift_reg <= next_shift;  // RL14
    bit_count <= next_count;
  end

  // Output moves after the falling edge; before the first rising edge
  // it shows zero, which is the unused top bit of the status byte.
  // An idle-high bus clock falls once before its first rise, so that
  // falling edge must not bring out the stale word of the last frame.
  always_ff @(negedge bus_clock or posedge chip_select_low) begin
    if (chip_select_low) begin
      out_bit <= 1'b0;
    end else if (fresh) begin
      out_bit <= 1'b0;  // RL5 RL9
    end else begin
      out_bit <= shift_reg[39];  // RL14
    end
  end

  // Last 40 bits before chip select rises form the command
  assign link.frame_word = shift_reg;  // RL18
  assign link.frame_full = at_full;
  assign serial_out      = out_bit;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  a_daisy_delay: assert property (@(posedge bus_clock) disable iff (chip_select_low)
    (at_full && !fresh) |-> shift_reg[39] == $past(serial_in, 40))  // RL16
    else $error("shift path delay is not 40 clocks");
  a_count_start: assert property (@(posedge bus_clock) disable iff (chip_select_low)
    fresh |=> (bit_count == 6'h01) && (shift_reg[39] == $past(link.resp_word[38])))  // RL5
    else $error("frame did not start from the response word");
  a_first_bit: assert property (@(posedge bus_clock) disable iff (chip_select_low)
    fresh |-> !out_bit)  // RL9
    else $error("first response bit is not the unused zero");
endmodule
`default_nettype wire

// ==== verilog/motor_driver_spi_slave.sv ====
// Purpose: Serial command port of a stepper driver, system clock side.
// Assumes: Bus clock at most half of sys_clk; chip select high between
//          frames long enough for the response word to settle.
// Notes:   Register file lives outside; this block issues commands,
//          fetches read data and builds the pipelined response.
//
// Summary of operation
// RL1: Frames are 40 bits, 32 data.
// RL2: Host holds chip select low whole frame.
// RL3: Bit 39 set means write, clear read.
// RL4: Every register moves as full 32 bits.
// RL5: A 40-bit response goes out every frame.
// RL6: After a read, return addressed register contents.
// RL7: After a write, echo the written data.
// RL8: Read frames change no register.
// RL9: Top byte is the status byte.
// RL10: Standstill and stall mirror driver status bits.
// RL11: Error and reset bits clear on status read.
// RL12: Status captured at frame end, sent next.
// RL13: Data is right aligned in field.
// RL14: Sample rising edge, drive after falling, MSB first.
// RL15: Host gives at least 40 clocks per frame.
// RL16: Extra bits emerge 40 clocks later.
// RL17: Chip select rise latches command and acts.
// RL18: Only the last 40 bits form command.
// RL19: Host keeps bus clock at most half sys_clk.
// RL20: After reset, response data is zero.
`timescale 1ns/100ps
`default_nettype none
module motor_driver_spi_slave (
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Serial pins; bus_clock is the link clock
  input  wire logic        bus_clock,
  input  wire logic        chip_select_low,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_en_n,
  // Command to the register file
  output logic             cmd_valid,
  output logic             direction_flag,
  output logic [6:0]       cmd_addr,
  output logic [31:0]      cmd_data,
  // Read lookup into the register file
  output logic [6:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  // Status sources and clear-on-read strobe
  input  wire logic [31:0] drv_status_word,
  input  wire logic [1:0]  global_status_reg,
  output logic             global_status_clear,
  // Status byte sent with the current response
  output logic [7:0]       frame_status_byte
);
  // ---------------------------------------------
  // Declarations
  // ---------------------------------------------
  frame_link_if link_bus ();               // Words across the clock boundary

  logic                            cs_sync;      // Chip select in sys_clk
  logic                            cs_prev;      // Last synchronised level
  spi_frame_pkg::frame_state_t     state;        // Frame-end sequencer
  spi_frame_pkg::frame_state_t     next_state;
  logic [39:0]                     command_word; // Latched command register
  logic                            frame_ok;     // Frame had 40 clocks or more
  logic [31:0]                     resp_data;    // Data field of next response
  logic                            cmd_pulse;    // Command strobe register
  logic                            clear_pulse;  // Status clear register

  // ---------------------------------------------
  // Link side
  // ---------------------------------------------
  // Shift path runs on the bus clock only
  frame_shifter u_shifter (
    .bus_clock       (bus_clock),
    .chip_select_low (chip_select_low),
    .serial_in       (serial_in),
    .serial_out      (serial_out),
    .link            (link_bus.link)
  );

  // Chip select is idle high, so reset to one
  level_sync #(
    .WIDTH      (1),
    .RESET_BITS (1'b1)
  ) u_cs_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (chip_select_low),
    .sync_out (cs_sync)
  );

  // ---------------------------------------------
  // Decoding
  // ---------------------------------------------
  // End of frame seen in sys_clk; the bus clock has stopped by then
  wire cs_rise = cs_sync & ~cs_prev;  // RL2 RL19

  // Fields of the latched command
  wire        cmd_is_write = command_word[spi_frame_pkg::DIR_BIT];  // RL3
  wire [6:0]  cmd_field    = command_word[spi_frame_pkg::ADDR_MSB:spi_frame_pkg::ADDR_LSB];
  wire [31:0] data_field   = command_word[31:0];  // RL1 RL4 RL13

  // A read of the global status word clears its two flags
  wire is_global_status_reg_read = frame_ok & ~cmd_is_write
                     & (cmd_field == spi_frame_pkg::GLOBAL_STATUS_ADDR);  // RL11

  // Status byte from the current sources; top nibble unused
  wire [7:0] next_status = {4'h0,
                            drv_status_word[spi_frame_pkg::DRV_STANDSTILL_BIT],
                            drv_status_word[spi_frame_pkg::DRV_STALL_BIT],
                            global_status_reg[spi_frame_pkg::GLOBAL_STATUS_REG_ERR_BIT],
                            global_status_reg[spi_frame_pkg::GLOBAL_STATUS_REG_RESET_BIT]};  // RL9 RL10 RL11

  // Read data must be sampled after rd_addr has been settled
  wire [31:0] next_resp = cmd_is_write ? data_field : rd_data;  // RL6 RL7

  // Response word handed to the link side
  assign link_bus.resp_word = {frame_status_byte, resp_data};  // RL5 RL9

  // ---------------------------------------------
  // Sequencer
  // ---------------------------------------------
  // Latch one cycle, act the next, then wait for the next frame
  always_comb begin
    next_state = state;
    case (state)
      spi_frame_pkg::ST_IDLE: begin
        if (cs_rise) begin
          next_state = spi_frame_pkg::ST_LATCH;
        end
      end
      spi_frame_pkg::ST_LATCH: begin
        next_state = spi_frame_pkg::ST_ACT;
      end
      spi_frame_pkg::ST_ACT: begin
        next_state = spi_frame_pkg::ST_IDLE;
      end
      default: begin
        next_state = spi_frame_pkg::ST_IDLE;
      end
    endcase
  end

  // State and edge history
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state   <= spi_frame_pkg::ST_IDLE;
      cs_prev <= 1'b1;
    end else begin
      state   <= next_state;
      cs_prev <= cs_sync;
    end
  end

  // ---------------------------------------------
  // Command register
  // ---------------------------------------------
  // Shift path is quiet here: chip select has been high more than three clocks
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      command_word <= 40'h0000000000;
      frame_ok     <= 1'b0;
      rd_addr      <= 7'h00;
    end else if (state == spi_frame_pkg::ST_LATCH) begin
      command_word <= link_bus.frame_word;  // RL17 RL18
      frame_ok     <= link_bus.frame_full;  // RL15
      rd_addr      <= link_bus.frame_word[spi_frame_pkg::ADDR_MSB:spi_frame_pkg::ADDR_LSB];
    end
  end

  // ---------------------------------------------
  // Act on the frame
  // ---------------------------------------------
  // Strobes pulse one cycle; a short frame issues nothing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_pulse   <= 1'b0;
      clear_pulse <= 1'b0;
    end else begin
      cmd_pulse   <= (state == spi_frame_pkg::ST_ACT) & frame_ok;  // RL17
      clear_pulse <= (state == spi_frame_pkg::ST_ACT) & is_global_status_reg_read;  // RL11
    end
  end

  // Command fields held until the next frame acts
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      direction_flag <= 1'b0;
      cmd_addr       <= 7'h00;
      cmd_data       <= 32'h00000000;
    end else if ((state == spi_frame_pkg::ST_ACT) && frame_ok) begin
      direction_flag <= cmd_is_write;  // RL3 RL8
      cmd_addr       <= cmd_field;
      cmd_data       <= data_field;
    end
  end

  assign cmd_valid           = cmd_pulse;
  assign global_status_clear = clear_pulse;

  // ---------------------------------------------
  // Response and status
  // ---------------------------------------------
  // Status captured every frame end, before its flags are cleared;
  // reset acts as if a read of zero data had gone before
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frame_status_byte <= spi_frame_pkg::STATUS_RESET;  // RL20
      resp_data         <= spi_frame_pkg::DATA_RESET;    // RL20
    end else if (state == spi_frame_pkg::ST_ACT) begin
      frame_status_byte <= next_status;  // RL12
      if (frame_ok) begin
        resp_data <= next_resp;  // RL6 RL7
      end
    end
  end

  // Pin driven while selected; follows the synchronised select
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serial_out_en_n <= 1'b1;
    end else begin
      serial_out_en_n <= cs_sync;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_cmd_strobe: assert property (cmd_valid |=> !cmd_valid)  // RL17
    else $error("command strobe longer than one cycle");

  a_frame_order: assert property (
    (cs_rise && state == spi_frame_pkg::ST_IDLE)
      |=> state == spi_frame_pkg::ST_LATCH ##1 state == spi_frame_pkg::ST_ACT
      ##1 state == spi_frame_pkg::ST_IDLE)  // RL17
    else $error("frame end not latched then acted on");

  a_read_return: assert property (
    (state == spi_frame_pkg::ST_ACT && frame_ok && !cmd_is_write)
      |=> resp_data == $past(rd_data) && rd_addr == cmd_addr)  // RL6
    else $error("read data not returned for the read address");

  a_write_echo: assert property (
    (state == spi_frame_pkg::ST_ACT && frame_ok && cmd_is_write)
      |=> resp_data == $past(command_word[31:0]) && direction_flag)  // RL7
    else $error("write data not echoed");

  a_read_nowrite: assert property (
    (state == spi_frame_pkg::ST_ACT && frame_ok && !cmd_is_write)
      |=> cmd_valid && !direction_flag)  // RL8
    else $error("read frame issued as a write");

  a_status_map: assert property (
    (state == spi_frame_pkg::ST_ACT)
      |=> frame_status_byte == {4'h0, $past(drv_status_word[31]),
                                $past(drv_status_word[24]), $past(global_status_reg)})  // RL10
    else $error("status byte does not mirror its sources");

  a_global_status_reg_clear: assert property (
    global_status_clear |-> cmd_valid && !direction_flag
      && cmd_addr == spi_frame_pkg::GLOBAL_STATUS_ADDR)  // RL11
    else $error("status flags cleared without a status read");

  a_short_frame: assert property (
    (state == spi_frame_pkg::ST_ACT && !frame_ok)
      |=> !cmd_valid && $stable(resp_data))  // RL15
    else $error("short frame was acted on");

  // Clear strobe is a single pulse per status read
  a_clear_pulse: assert property (global_status_clear |=> !global_status_clear)  // RL11
    else $error("status clear longer than one cycle");

  // Lookup address follows the frame just latched
  a_latch_addr: assert property (
    (state == spi_frame_pkg::ST_LATCH)
      |=> rd_addr == command_word[spi_frame_pkg::ADDR_MSB:spi_frame_pkg::ADDR_LSB])  // RL17
    else $error("lookup address not taken from the frame");

  // Full 32-bit field handed on unchanged, right aligned
  a_field_copy: assert property (
    (state == spi_frame_pkg::ST_ACT && frame_ok)
      |=> cmd_data == $past(command_word[31:0])
      && cmd_addr == $past(command_word[38:32]))  // RL4
    else $error("command fields not copied whole");

  // Unused nibble of the status byte never carries data
  a_status_top: assert property (frame_status_byte[7:4] == 4'h0)  // RL9
    else $error("unused status bits set");

  // Output pin is driven only while the frame is selected
  a_pin_enable: assert property (
    (state != spi_frame_pkg::ST_IDLE) |-> serial_out_en_n)  // RL5
    else $error("output driven after chip select rose");
endmodule
`default_nettype wire

// ==== sim/spi_host_model.sv ====
// Purpose: Behavioural serial bus master driving the command port.
// Assumes: Bus clock idles high and stands still outside frames.
// Notes:   The released data line shows the inverse of its last bit.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // Pins toward the port
  output logic      bus_clock,
  output logic      chip_select_low,
  output logic      serial_in,
  // Pin from the port
  input  wire logic serial_out
);
  // ---------------------------------------------
  // Idle levels
  // ---------------------------------------------
  initial begin
    bus_clock       = 1'b1;
    chip_select_low = 1'b1;
    serial_in       = 1'b0;
  end
  // ---------------------------------------------
  // One frame of n bits, MSB first
  // ---------------------------------------------
  // Half period of 40 ns keeps the bus clock well under sys_clk/2
  task automatic xfer(input int n, input logic [79:0] tx, output logic [79:0] rx);
    rx = '0;
    // Odd offset keeps the link unrelated in phase to sys_clk
    #3.7 chip_select_low = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      bus_clock = 1'b0;
      serial_in = tx[i];
      #40 bus_clock = 1'b1;
      rx = {rx[78:0], serial_out};
      #40;
    end
    chip_select_low = 1'b1;
    // No stale bit is left on a released line
    serial_in = ~serial_in;
    // Long select-high gap lets the command act and the response settle
    #236.3;
  endtask
endmodule
`default_nettype wire

// ==== sim/motor_driver_spi_slave_test.sv ====
// Purpose: Self-checking bench of the serial command port.
// Assumes: Register file and status sources are modelled here.
// Notes:   Expected responses track the pipelined read-back.
`timescale 1ns/100ps
`default_nettype none
module motor_driver_spi_slave_test;
  // ---------------------------------------------
  // Signals
  // ---------------------------------------------
  logic        sys_clk, rst_n;
  wire         bus_clock, chip_select_low, serial_in, serial_out, serial_out_en_n;
  wire         cmd_valid, direction_flag, global_status_clear;
  wire  [6:0]  cmd_addr, rd_addr;
  wire  [31:0] cmd_data, rd_data;
  wire  [7:0]  frame_status_byte;
  logic [31:0] drv_status_word, exp_data;
  logic [1:0]  global_status_reg;
  logic [7:0]  exp_stat;
  logic [79:0] rx;
  int          err_count, total_checks, n_cmd, n_clr;
  // Register contents differ for every address
  function automatic logic [31:0] reg_val(input logic [6:0] a);
    return {a, 8'h5A, 10'h000, a};
  endfunction
  function automatic logic [7:0] stat_now();
    return {4'h0, drv_status_word[31], drv_status_word[24], global_status_reg};
  endfunction
  assign rd_data = reg_val(rd_addr);
  // ---------------------------------------------
  // Instances
  // ---------------------------------------------
  spi_host_model host (.bus_clock(bus_clock), .chip_select_low(chip_select_low),
                       .serial_in(serial_in), .serial_out(serial_out));
  motor_driver_spi_slave uut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_clock(bus_clock),
    .chip_select_low(chip_select_low), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en_n(serial_out_en_n), .cmd_valid(cmd_valid), .direction_flag(direction_flag),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .drv_status_word(drv_status_word), .global_status_reg(global_status_reg),
    .global_status_clear(global_status_clear), .frame_status_byte(frame_status_byte));
  // ---------------------------------------------
  // Clock, pulse counters, checks
  // ---------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (global_status_clear === 1'b1) begin
      n_clr++;
      check(cmd_valid, 1'b1, "clear without command");
    end
  end
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic set_stat(input logic [31:0] d, input logic [1:0] g);
    @(posedge sys_clk);
    #1;
    drv_status_word = d;
    global_status_reg = g;
  endtask
  // One frame, judged against the pipelined expectation
  task automatic run(input int n, input logic [79:0] tx);
    int          c0;
    logic [39:0] exp_w;
    c0 = n_cmd;
    exp_w = {exp_stat, exp_data};
    fork
      host.xfer(n, tx, rx);
      begin
        #1000 check(serial_out_en_n, 1'b0, "drive enable");
      end
    join
    if (n < 40) exp_w = (exp_w >> (40 - n)) << (40 - n);
    check(40'((rx << (80 - n)) >> 40), exp_w, "response");
    check(n_cmd - c0, (n >= 40), "command count");
    check(serial_out_en_n, 1'b1, "release");
    exp_stat = stat_now();
    check(frame_status_byte, exp_stat, "status byte");
    if (n == 80) check(rx[39:0], tx[79:40], "chain");
    if (n >= 40) begin
      check({direction_flag, cmd_addr, cmd_data}, tx[39:0], "command fields");
      exp_data = tx[39] ? tx[31:0] : reg_val(tx[38:32]);
    end
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_reset();
    check({cmd_valid, direction_flag, cmd_addr, cmd_data}, 40'h0000000000, "reset fields");
    check(frame_status_byte, 8'h00, "reset status");
    run(40, 40'h6F00000000);
  endtask
  task automatic t_pipeline();
    run(40, 40'h6FFFFFFFFF);
    check(direction_flag, 1'b0, "read flag");
    run(40, 40'hEC00ABCDEF);
    run(40, 40'hEC00123456);
  endtask
  task automatic t_status();
    for (int b = 0; b < 4; b++) begin
      set_stat(32'h7EFFFFFF | (b == 3 ? 32'h80000000 : b == 2 ? 32'h01000000 : 32'h0),
               b < 2 ? 2'(1 << b) : 2'b00);
      run(40, 40'h2200000011);
    end
  endtask
  task automatic t_global_status_reg_clear();
    int c;
    set_stat(32'h00000000, 2'b11);
    c = n_clr;
    run(40, 40'h8100000003);
    check(n_clr - c, 0, "clear on write");
    run(40, 40'h0100000000);
    check(n_clr - c, 1, "clear on read");
    set_stat(32'h00000000, 2'b00);
  endtask
  task automatic t_short();
    run(20, 80'h00000000000000000EC12);
    run(40, 40'h5500000000);
  endtask
  task automatic t_long();
    run(80, {40'h9876543210, 40'hEC0000BEEF});
    run(40, 40'h0000000000);
  endtask
  // ---------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------
  initial begin
    rst_n = 1'b0;
    drv_status_word = 32'h00000000;
    global_status_reg = 2'b00;
    exp_stat = 8'h00;
    exp_data = 32'h00000000;
    err_count = 0;
    total_checks = 0;
    n_cmd = 0;
    n_clr = 0;
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_pipeline();
    t_status();
    t_global_status_reg_clear();
    t_short();
    t_long();
    test_done();
  end
  initial begin
    #200000;
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
